// ---- design/mlssp_cfg.sv ----
// volatile and non-volatile copies of the interface mode byte
// assumes the memory core issues the write strobes
`timescale 1ns/1ps
`default_nettype none

module mlssp_cfg
   import mlssp_pkg::*;
#(
   parameter logic [7:0] NV_RESET = CFG_NV_RESET
) (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       hw_rst,
   input  wire logic       vol_wr,
   input  wire logic       nv_wr,
   input  wire logic [7:0] wdata,
   output var  logic [1:0] cmd_w_q
);

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   function automatic logic [1:0] cmd_dec(input logic [7:0] v);
      if (v[CFG_FOUR_LANE_BIT]) begin
         cmd_dec = LW_FOUR;
      end else if (v[CFG_TWO_LANE_BIT]) begin
         cmd_dec = LW_TWO;
      end else begin
         cmd_dec = LW_ONE;
      end
   endfunction

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [7:0] vol_q;
   logic [7:0] vol_d;
   logic [7:0] nv_q;
   logic [7:0] nv_d;
   logic [1:0] cmd_w_d;

   always_comb begin
      nv_d  = nv_wr ? wdata : nv_q;
      vol_d = (vol_wr | nv_wr) ? wdata : vol_q;
      if (hw_rst) begin
         vol_d = nv_q;
      end
      cmd_w_d = cmd_dec(vol_d);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nv_q    <= NV_RESET;
         vol_q   <= NV_RESET;
         cmd_w_q <= cmd_dec(NV_RESET);
      end else begin
         nv_q    <= nv_d;
         vol_q   <= vol_d;
         cmd_w_q <= cmd_w_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   reload_copy_a : assert property (@(posedge mclk) disable iff (!rst_n)
      hw_rst |=> vol_q == $past(nv_q))
      else $error("volatile copy not reloaded on pin reset");

   four_wins_a : assert property (@(posedge mclk) disable iff (!rst_n)
      vol_q[CFG_FOUR_LANE_BIT] && vol_q[CFG_TWO_LANE_BIT] |-> cmd_w_q == LW_FOUR)
      else $error("four lane mode lost precedence");

endmodule
`default_nettype wire

// ---- design/mlssp_port.sv ----
// serial slave front end: pins, phase sequencing, lane widths, data rate
// assumes sck and cs_n come from the master and run well below mclk
`timescale 1ns/1ps
`default_nettype none

module mlssp_port
   import mlssp_pkg::*;
#(
   parameter logic [7:0] NV_RESET = CFG_NV_RESET
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              cs_n,
   input  wire logic              sck,
   input  wire logic [3:0]        lane_in,
   output var  logic [3:0]        lane_out_q,
   output var  logic [3:0]        lane_oe_q,
   input  wire logic              cfg_vol_wr,
   input  wire logic              cfg_nv_wr,
   input  wire logic [7:0]        cfg_wdata,
   input  wire logic              soft_reset,
   input  wire mlssp_op_info_type op_info,
   input  wire logic [7:0]        rd_data,
   output var  mlssp_req_type     req_q,
   output var  logic [1:0]        cmd_w_q,
   output var  logic              clk_mode3_q,
   output var  logic              write_protect_n_q
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [4:0] lane_w(input logic [1:0] c);
      unique case (c)
         LW_TWO:  lane_w = 5'h02;
         LW_FOUR: lane_w = 5'h04;
         default: lane_w = 5'h01;
      endcase
   endfunction

   // msb arrives first, highest lane carries the higher bit
   function automatic logic [23:0] take(input logic [23:0] sh, input logic [3:0] ln,
                                        input logic [1:0] c);
      unique case (c)
         LW_TWO:  take = {sh[21:0], ln[1:0]};
         LW_FOUR: take = {sh[19:0], ln};
         default: take = {sh[22:0], ln[0]};
      endcase
   endfunction

   function automatic logic [3:0] put(input logic [7:0] b, input logic [1:0] c);
      unique case (c)
         LW_TWO:  put = {2'h0, b[7:6]};
         LW_FOUR: put = b[7:4];
         default: put = {2'h0, b[7], 1'h0};
      endcase
   endfunction

   function automatic logic [3:0] lane_mask(input logic [1:0] c);
      unique case (c)
         LW_TWO:  lane_mask = 4'h3;
         LW_FOUR: lane_mask = 4'hf;
         default: lane_mask = 4'h2;
      endcase
   endfunction

   function automatic logic [1:0] data_w(input logic [1:0] cmdw, input logic [1:0] ext);
      data_w = (cmdw != LW_ONE) ? cmdw : ext;
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers and mode store
   // ------------------------------------------------------------
   logic [5:0] pin_s;
   logic       cs_s;
   logic       sck_s;
   logic [3:0] ln_s;
   logic       hw_rst;
   logic       quad_busy;

   mlssp_sync #(.WIDTH(6), .RST_VAL(6'h3f)) u_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .din   ({cs_n, sck, lane_in}),
      .dout  (pin_s)
   );

   assign cs_s  = pin_s[5];
   assign sck_s = pin_s[4];
   assign ln_s  = pin_s[3:0];

   mlssp_cfg #(.NV_RESET(NV_RESET)) u_cfg (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .hw_rst  (hw_rst),
      .vol_wr  (cfg_vol_wr),
      .nv_wr   (cfg_nv_wr),
      .wdata   (cfg_wdata),
      .cmd_w_q (cmd_w_q)
   );

   // ------------------------------------------------------------
   // edge detection
   // ------------------------------------------------------------
   logic sck_p_q;
   logic sck_p_d;
   logic cs_p_q;
   logic cs_p_d;
   logic rise;
   logic fall;
   logic cs_fall;
   logic [1:0] l3_hold_q;
   logic [1:0] l3_hold_d;

   always_comb begin
      sck_p_d = sck_s;
      cs_p_d  = cs_s;
      l3_hold_d = {l3_hold_q[0], lane_oe_q[3]};
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sck_p_q <= 1'h1;
         cs_p_q  <= 1'h1;
         l3_hold_q <= 2'h0;
      end else begin
         sck_p_q <= sck_p_d;
         cs_p_q  <= cs_p_d;
         l3_hold_q <= l3_hold_d;
      end
   end

   assign rise    = sck_s & ~sck_p_q;
   assign fall    = ~sck_s & sck_p_q;
   assign cs_fall = ~cs_s & cs_p_q;

   // ------------------------------------------------------------
   // transfer sequencer
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_OPC   = 7'b0000010,
      ST_DEC   = 7'b0000100,
      ST_ADDR  = 7'b0001000,
      ST_WDATA = 7'b0010000,
      ST_RDATA = 7'b0100000,
      ST_IGN   = 7'b1000000
   } mlssp_state_type;

   mlssp_state_type   st_q;
   mlssp_state_type   st_d;
   logic [4:0]        cnt_q;
   logic [4:0]        cnt_d;
   logic [23:0]       sh_q;
   logic [23:0]       sh_d;
   logic [7:0]        osh_q;
   logic [7:0]        osh_d;
   logic [2:0]        ocnt_q;
   logic [2:0]        ocnt_d;
   logic [1:0]        wc_q;
   logic [1:0]        wc_d;
   logic [1:0]        ext_q;
   logic [1:0]        ext_d;
   logic              ddr_q;
   logic              ddr_d;
   logic              live_q;
   logic              live_d;
   logic              ogo_q;
   logic              ogo_d;
   mlssp_op_info_type info_q;
   mlssp_op_info_type info_d;
   logic              m3_d;
   logic              wp_d;
   logic [3:0]        lo_d;
   logic [3:0]        oe_d;
   mlssp_req_type     rq_d;
   logic [4:0]        wadd;
   logic [4:0]        nxt;
   logic              smp;
   logic              drive;
   logic [7:0]        obyte;

   // pin reset is only honoured while lane three is not carrying data; the hold
   // covers the two synchroniser cycles in which our own last quad bit lingers
   assign quad_busy = (cmd_w_q == LW_FOUR) | (ext_q == LW_FOUR) | (|l3_hold_q);
   assign hw_rst    = ~ln_s[3] & ~quad_busy;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      osh_d  = osh_q;
      ocnt_d = ocnt_q;
      wc_d   = wc_q;
      ext_d  = ext_q;
      ddr_d  = ddr_q;
      live_d = live_q;
      ogo_d  = ogo_q;
      info_d = info_q;
      m3_d   = clk_mode3_q;
      lo_d   = lane_out_q;
      oe_d   = lane_oe_q;
      rq_d   = '0;
      wp_d   = quad_busy ? write_protect_n_q : ln_s[2];
      wadd   = lane_w(wc_q);
      nxt    = cnt_q + wadd;
      smp    = rise | (fall & live_q);
      drive  = fall | (rise & ddr_q & ogo_q);
      obyte  = (ocnt_q == 3'h0) ? rd_data : osh_q;
      if (cs_s) begin
         st_d  = ST_IDLE;
         oe_d  = 4'h0;
         ext_d = LW_ONE;
         ddr_d = 1'h0;
         live_d = 1'h0;
         ogo_d = 1'h0;
      end else if (hw_rst | soft_reset) begin
         st_d  = ST_IGN;
         oe_d  = 4'h0;
         ext_d = LW_ONE;
         ddr_d = 1'h0;
         live_d = 1'h0;
      end else if (cs_fall) begin
         st_d   = ST_OPC;
         m3_d   = sck_s;
         wc_d   = cmd_w_q;
         ext_d  = LW_ONE;
         cnt_d  = 5'h00;
         ocnt_d = 3'h0;
      end else begin
         unique case (st_q)
            ST_IDLE, ST_IGN: begin
               st_d = st_q;
            end
            ST_OPC: begin
               if (rise) begin
                  sh_d  = take(sh_q, ln_s, wc_q);
                  cnt_d = nxt;
                  if (nxt == BYTE_BITS) begin
                     rq_d.op_valid = 1'h1;
                     rq_d.op       = sh_d[7:0];
                     cnt_d         = 5'h00;
                     st_d          = ST_DEC;
                  end
               end
            end
            ST_DEC: begin
               info_d = op_info;
               ext_d  = data_w(cmd_w_q, op_info.ext);
               ddr_d  = (cmd_w_q == LW_FOUR) & op_info.ddr & op_info.has_addr
                        & ~clk_mode3_q;
               if (op_info.reserved) begin
                  st_d = ST_IGN;
               end else if (op_info.has_addr) begin
                  st_d = ST_ADDR;
                  wc_d = (cmd_w_q != LW_ONE) ? cmd_w_q
                         : (op_info.io_var ? op_info.ext : LW_ONE);
               end else begin
                  st_d = op_info.is_read ? ST_RDATA : ST_WDATA;
                  rq_d.rd_req = op_info.is_read;
                  wc_d = data_w(cmd_w_q, op_info.ext);
               end
            end
            ST_ADDR: begin
               if (smp) begin
                  sh_d  = take(sh_q, ln_s, wc_q);
                  cnt_d = nxt;
                  if (rise & ddr_q) begin
                     live_d = 1'h1;
                  end
                  if (nxt == ADDR_BITS) begin
                     rq_d.addr_valid = 1'h1;
                     rq_d.addr       = sh_d[ADDR_KEEP-1:0];
                     cnt_d           = 5'h00;
                     wc_d            = data_w(cmd_w_q, info_q.ext);
                     if (info_q.is_read) begin
                        st_d        = ST_RDATA;
                        rq_d.rd_req = 1'h1;
                        live_d      = 1'h0;
                     end else begin
                        st_d   = ST_WDATA;
                        live_d = ddr_q | (rise & ddr_q);
                     end
                  end
               end
            end
            ST_WDATA: begin
               if (smp) begin
                  sh_d  = take(sh_q, ln_s, wc_q);
                  cnt_d = nxt;
                  if (nxt == BYTE_BITS) begin
                     rq_d.wr_valid = 1'h1;
                     rq_d.wr_data  = sh_d[7:0];
                     cnt_d         = 5'h00;
                  end
               end
            end
            ST_RDATA: begin
               if (drive) begin
                  // next byte is requested as soon as one is taken, which
                  // gives the core a whole byte time to answer
                  ogo_d  = 1'h1;
                  lo_d   = put(obyte, wc_q);
                  oe_d   = lane_mask(wc_q);
                  osh_d  = obyte << wadd[2:0];
                  ocnt_d = ocnt_q + wadd[2:0];
                  rq_d.rd_req = (ocnt_q == 3'h0);
               end
            end
            default: begin
               st_d = ST_IGN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_d_reg_reset: begin
            st_q              <= ST_IDLE;
            cnt_q             <= 5'h00;
            sh_q              <= 24'h000000;
            osh_q             <= 8'h00;
            ocnt_q            <= 3'h0;
            wc_q              <= LW_ONE;
            ext_q             <= LW_ONE;
            ddr_q             <= 1'h0;
            live_q            <= 1'h0;
            ogo_q             <= 1'h0;
            info_q            <= '0;
            clk_mode3_q       <= 1'h0;
            write_protect_n_q <= 1'h1;
            lane_out_q        <= 4'h0;
            lane_oe_q         <= 4'h0;
            req_q             <= '0;
         end
      end else begin
         st_q              <= st_d;
         cnt_q             <= cnt_d;
         sh_q              <= sh_d;
         osh_q             <= osh_d;
         ocnt_q            <= ocnt_d;
         wc_q              <= wc_d;
         ext_q             <= ext_d;
         ddr_q             <= ddr_d;
         live_q            <= live_d;
         ogo_q             <= ogo_d;
         info_q            <= info_d;
         clk_mode3_q       <= m3_d;
         write_protect_n_q <= wp_d;
         lane_out_q        <= lo_d;
         lane_oe_q         <= oe_d;
         req_q             <= rq_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   deselect_float_a : assert property (cs_s |=> lane_oe_q == 4'h0)
      else $error("lanes driven while deselected");

   opcode_first_a : assert property (cs_fall && !hw_rst && !soft_reset
      |=> st_q == ST_OPC ##0 req_q.addr_valid == 1'h0)
      else $error("select did not open an opcode phase");

   single_start_a : assert property (cs_fall |=> ext_q == LW_ONE)
      else $error("transfer did not start single lane");

   single_return_a : assert property ($rose(cs_s) |=> st_q == ST_IDLE && ext_q == LW_ONE)
      else $error("deselect did not restore single lane");

   single_out_a : assert property ((lane_oe_q != 4'h0 && wc_q == LW_ONE)
      |-> lane_oe_q == 4'h2)
      else $error("single lane read not on lane one");

   quad_lanes_a : assert property ((lane_oe_q != 4'h0 && wc_q == LW_FOUR)
      |-> lane_oe_q == 4'hf)
      else $error("quad read not on four lanes");

   opcode_narrow_a : assert property ((st_q == ST_OPC && cmd_w_q == LW_ONE)
      |-> wc_q == LW_ONE)
      else $error("opcode widened outside command modes");

   ddr_gate_a : assert property (ddr_q |-> cmd_w_q == LW_FOUR && !clk_mode3_q)
      else $error("double rate outside four lane mode 0");

   fall_drive_a : assert property ($changed(lane_out_q)
      |-> $past(fall) || $past(rise && ddr_q))
      else $error("output changed off the falling edge");

endmodule
`default_nettype wire

// ---- design/mlssp_sync.sv ----
// two-stage synchroniser for the serial pins
// assumes inputs are asynchronous to mclk and change slowly against it
`timescale 1ns/1ps
`default_nettype none

module mlssp_sync #(
   parameter int               WIDTH   = 6,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);

   // ------------------------------------------------------------
   // stages
   // ------------------------------------------------------------
   // first stage feeds only the second one; nothing else may look at it
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_q <= RST_VAL;
         dout   <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         dout   <= sync_d;
      end
   end

endmodule
`default_nettype wire

// ---- pkg/mlssp_pkg.sv ----
// constants, carrier types and mode codes of the multi-lane serial slave port
// assumes one clock (mclk) and pins that are synchronised before use
//
// Summary of operation
// - after select the first byte is the opcode, then address, then data
// - single lane: opcode, address, write data on lane zero, read on lane one
// - variants have no setting; start single lane, switch per received opcode
// - deselect or any reset drops variant widths to single lane; command mode follows the volatile mode bits
// - quad reuses protect and reset pins as lanes two and three
// - data variants: opcode and address on lane zero, read data widened
// - io variants: opcode on lane zero, address and data widened both ways
// - config bit 4 set enters two lane command mode, clear leaves it
// - two lane command mode moves every phase as bit pairs
// - config bit 6 set enters four lane command mode, clear leaves it
// - four lane command mode moves every phase as nibbles
// - volatile mode bits reload from non-volatile copy at power-up and pin reset
// - opcode always single rate; special opcodes make later phases double rate (here only in four lane command mode)
// - double rate only for memory read and write special opcodes
// - while deselected ignore inputs and keep outputs undriven (here the reset and protect pins are still sampled while deselected)
// - sample on rising edges, change outputs on falling edges, msb first
// - address and data shift most significant bit first
// - address is three bytes; only the low 20 bits are kept
// - master makes the clock and starts transfers; device only responds
// - clock level at select picks mode 0 or 3; double rate mode 0 only
// - double rate: first address bit on first rise after opcode ends

package mlssp_pkg;

   // ------------------------------------------------------------
   // lane width codes
   // ------------------------------------------------------------
   localparam logic [1:0] LW_ONE  = 2'h0;
   localparam logic [1:0] LW_TWO  = 2'h1;
   localparam logic [1:0] LW_FOUR = 2'h2;

   // ------------------------------------------------------------
   // frame geometry and configuration bits
   // ------------------------------------------------------------
   localparam logic [4:0] BYTE_BITS         = 5'h08;
   localparam logic [4:0] ADDR_BITS         = 5'h18;
   localparam int         ADDR_KEEP         = 20;
   localparam int         CFG_TWO_LANE_BIT  = 4;
   localparam int         CFG_FOUR_LANE_BIT = 6;
   localparam logic [7:0] CFG_NV_RESET      = 8'h00;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       reserved;
      logic       has_addr;
      logic       is_read;
      logic       io_var;
      logic       ddr;
      logic [1:0] ext;
   } mlssp_op_info_type;

   typedef struct packed {
      logic                 op_valid;
      logic [7:0]           op;
      logic                 addr_valid;
      logic [ADDR_KEEP-1:0] addr;
      logic                 wr_valid;
      logic [7:0]           wr_data;
      logic                 rd_req;
   } mlssp_req_type;

endpackage

// ---- verification/mlssp_master.sv ----
// serial bus master model: select, clock and lane drive of the slave port
// assumes the bench resolves the lane wires and returns them on lane_in
`timescale 1ns/1ps
`default_nettype none
module mlssp_master (
   input  wire logic [3:0] lane_in,
   input  wire logic       mclk,
   output var  logic       cs_n,
   output var  logic       sck,
   output var  logic [3:0] m_out,
   output var  logic [3:0] m_oe,
   output var  logic [7:0] rd_byte,
   output var  logic       rd_stb
);
   // ------
   // half period 8 mclk, twice what the port needs
   // ------
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      m_out = 4'h0;
      m_oe = 4'h0;
      rd_byte = 8'h00;
      rd_stb = 1'b0;
   end
   task automatic half();
      repeat (8) @(negedge mclk);
   endtask
   task automatic cyc(input int w, input logic [3:0] d, input logic drv, output logic [3:0] q);
      m_oe = drv ? 4'((1 << w) - 1) : 4'h0;
      m_out = d;
      half();
      sck = 1'b1;
      q = lane_in;
      half();
      sck = 1'b0;
   endtask
   task automatic put(input int w, input logic [7:0] b);
      logic [3:0] q;
      for (int k = 0; k < 8 / w; k++) begin
         cyc(w, 4'((b >> (8 - w * (k + 1))) & ((1 << w) - 1)), 1'b1, q);
      end
   endtask
   // one byte on four lanes, high nibble on the rise and low nibble on the fall;
   // lanes change mid-half so neither edge sees them move
   task automatic dput(input logic [7:0] b);
      m_oe = 4'hf;
      repeat (4) @(negedge mclk);
      m_out = b[7:4];
      repeat (4) @(negedge mclk);
      sck = 1'b1;
      repeat (4) @(negedge mclk);
      m_out = b[3:0];
      half();
      sck = 1'b0;
   endtask
   task automatic get(input int w);
      logic [3:0] q;
      logic [7:0] r;
      r = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
         cyc(w, 4'h0, 1'b0, q);
         r = 8'((r << w) | (w == 1 ? 4'(q[1]) : q & 4'((1 << w) - 1)));
      end
      rd_byte = r;
      rd_stb = 1'b1;
      @(negedge mclk);
      rd_stb = 1'b0;
   endtask
   task automatic frame(input int ow, aw, dw, input logic [7:0] op, input logic [23:0] a,
                        input logic rd, m3, input logic [7:0] wd);
      sck = m3;
      half();
      cs_n = 1'b0;
      half();
      sck = 1'b0;
      put(ow, op);
      // a width of 8 stands for four lanes on both clock edges
      for (int k = 0; k < 3; k++) begin
         if (aw > 4) dput(a[23 - 8 * k -: 8]);
         else put(aw, a[23 - 8 * k -: 8]);
      end
      for (int k = 0; k < 2; k++) begin
         if (rd) get(dw);
         else if (dw > 4) dput(8'(wd + k));
         else put(dw, 8'(wd + k));
      end
      sck = m3;
      half();
      m_oe = 4'h0;
      cs_n = 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// ---- verification/multi_lane_serial_slave_port_test.sv ----
// self-checking bench of the multi-lane serial slave port
// assumes the master model in its own file; released lanes sit at pin_pull
`timescale 1ns/1ps
`default_nettype none
module multi_lane_serial_slave_port_test;
   import mlssp_pkg::*;
   logic              mclk, rst_n, cfg_vol_wr, cfg_nv_wr, cs_n, sck, rd_stb;
   logic              cur_m3, cur_res, dut_m3, wp_n;
   logic [3:0]        lane_w, m_out, m_oe, pin_pull, dut_out, dut_oe;
   logic [7:0]        cfg_wdata, rd_data, rd_byte;
   logic [1:0]        cmd_w;
   logic [15:0]       rnd;
   mlssp_op_info_type op_info;
   mlssp_req_type     req;
   logic [19:0]       expq[$];
   int                n_mismatch, compares, hi_cnt;
   // ------
   // wires: device wins, then master, else the pull level the bench sets
   // ------
   assign lane_w = (dut_oe & dut_out) | (~dut_oe & m_oe & m_out) | (~dut_oe & ~m_oe & pin_pull);
   mlssp_port dut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .lane_in(lane_w),
      .lane_out_q(dut_out), .lane_oe_q(dut_oe), .cfg_vol_wr(cfg_vol_wr), .cfg_nv_wr(cfg_nv_wr),
      .cfg_wdata(cfg_wdata), .soft_reset(1'b0), .op_info(op_info), .rd_data(rd_data),
      .req_q(req), .cmd_w_q(cmd_w), .clk_mode3_q(dut_m3), .write_protect_n_q(wp_n));
   mlssp_master m (.mclk(mclk), .lane_in(lane_w), .cs_n(cs_n), .sck(sck), .m_out(m_out),
      .m_oe(m_oe), .rd_byte(rd_byte), .rd_stb(rd_stb));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic bad(input string s);
      n_mismatch++;
      $display("ERROR %0t %s", $time, s);
   endtask
   task automatic cmp(input logic [19:0] g, e);
      compares++;
      if (g !== e) bad("value differs");
   endtask
   task automatic chk(input logic [19:0] g);
      compares++;
      if (expq.size() == 0) bad("unexpected result");
      else if (expq.pop_front() !== g) bad("result differs");
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      hi_cnt <= cs_n ? hi_cnt + 1 : 0;
      if (hi_cnt > 6 && dut_oe !== 4'h0) bad("lanes driven while idle");
      if (cur_res && dut_oe !== 4'h0) bad("lanes driven after bad opcode");
      if (req.op_valid) chk(20'(req.op));
      if (req.op_valid) cmp(20'(dut_m3), 20'(cur_m3));
      if (req.addr_valid) chk(req.addr);
      if (req.wr_valid) chk(20'(req.wr_data));
      if (rd_stb) chk(20'(rd_byte));
   end
   task automatic run(input logic [1:0] ext, input logic io, rd, res, m3, input int ow, aw, dw);
      logic [23:0] a;
      logic [7:0]  op, wd;
      rnd = lfsr(rnd);
      op = rnd[7:0];
      wd = rnd[15:8];
      rnd = lfsr(rnd);
      a = {rnd, op};
      if (m3) a[23:20] = 4'h0;
      rnd = lfsr(rnd);
      @(negedge mclk);
      op_info = '{res, 1'b1, rd, io, 1'(aw > 4), ext};
      rd_data = rnd[7:0];
      cur_m3 = m3;
      cur_res = res;
      expq.push_back(20'(op));
      if (!res) expq.push_back(a[19:0]);
      // a refused opcode leaves lane one to its pull-up, so reads return all ones
      for (int k = 0; k < 2; k++) begin
         if (rd || !res) expq.push_back(20'(res ? 8'hff : (rd ? rnd[7:0] : 8'(wd + k))));
      end
      m.frame(ow, aw, dw, op, a, rd, m3, wd);
      cur_res = 1'b0;
   endtask
   task automatic cfg(input logic nv, input logic [7:0] v, input logic [1:0] e);
      @(negedge mclk);
      cfg_wdata = v;
      cfg_nv_wr = nv;
      cfg_vol_wr = !nv;
      @(negedge mclk);
      cfg_nv_wr = 1'b0;
      cfg_vol_wr = 1'b0;
      @(negedge mclk);
      cmp(20'(cmd_w), 20'(e));
   endtask
   initial begin
      rst_n = 1'b0;
      {cfg_vol_wr, cfg_nv_wr, cfg_wdata, rd_data, cur_m3, cur_res} = '0;
      op_info = '0;
      pin_pull = 4'hf;
      rnd = 16'hbe54;
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      cmp(20'(cmd_w), 20'(LW_ONE));
      pin_pull[2] = 1'b0;
      repeat (5) @(negedge mclk);
      cmp(20'(wp_n), 20'h00000);
      pin_pull[2] = 1'b1;
      run(LW_ONE, 0, 1, 0, 0, 1, 1, 1);
      run(LW_ONE, 0, 0, 0, 1, 1, 1, 1);
      run(LW_TWO, 0, 1, 0, 0, 1, 1, 2);
      run(LW_FOUR, 0, 1, 0, 0, 1, 1, 4);
      run(LW_TWO, 1, 0, 0, 0, 1, 2, 2);
      run(LW_FOUR, 1, 1, 0, 0, 1, 4, 4);
      run(LW_ONE, 0, 1, 0, 0, 1, 1, 1);
      run(LW_ONE, 0, 1, 1, 0, 1, 1, 1);
      cfg(0, 8'h10, LW_TWO);
      run(LW_ONE, 0, 1, 0, 0, 2, 2, 2);
      cfg(0, 8'h50, LW_FOUR);
      cfg(0, 8'h40, LW_FOUR);
      run(LW_ONE, 0, 0, 0, 0, 4, 4, 4);
      run(LW_ONE, 0, 0, 0, 0, 4, 8, 8);
      cfg(0, 8'h00, LW_ONE);
      cfg(1, 8'h10, LW_TWO);
      cfg(0, 8'h00, LW_ONE);
      pin_pull[3] = 1'b0;
      repeat (4) @(negedge mclk);
      pin_pull[3] = 1'b1;
      repeat (4) @(negedge mclk);
      cmp(20'(cmd_w), 20'(LW_TWO));
      if (expq.size() != 0) bad("results missing");
      summarize();
   end
   initial begin
      hi_cnt = 0;
      n_mismatch = 0;
      compares = 0;
      repeat (60000) @(posedge mclk);
      bad("timeout");
      summarize();
   end
endmodule
`default_nettype wire
